/* File: inc/fpc_defines.svh */
// constants for the flash program command and boot option block
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH
`define FPC_IR_W 10
`define FPC_CMD_VERIFY_READ 10'h205
`define FPC_CMD_BGP_ENTRY 10'h199
`define FPC_CMD_BGP_EXIT 10'h166
`define FPC_CMD_ENTRY_TRISTATE 10'h2CC
`define FPC_CMD_ENTRY_HELD 10'h233
`define FPC_CMD_EXIT 10'h201
`define FPC_CMD_BYPASS 10'h3FF
`define FPC_IR_CAPTURE 10'h001
`define FPC_DR_W 32
`define FPC_ADDR_W 23
`define FPC_DR_EXPLICIT_BIT 31
`define FPC_CNT_W 25
`define FPC_CLK_MHZ 125
`define FPC_EXIT_WAIT_US 200
`define FPC_CFG_MAX_MS 139.6
`define FPC_REG_CTRL 8'h00
`define FPC_REG_OPT 8'h04
`define FPC_REG_STAT 8'h08
`define FPC_REG_CTIME 8'h0C
`define FPC_REG_FADDR 8'h10
`define FPC_CTRL_BURST_BIT 0
`define FPC_OPT_W 19
`define FPC_OPT_RST 19'h7FFC1
`define FPC_STAT_IR_LSB 16
`endif

/* File: inc/fpc_pkg.sv */
// types for the flash program command and boot option block
`include "fpc_defines.svh"
package fpc_pkg;
    typedef enum logic [3:0] {
        TAP_RESET = 4'h0, TAP_RTI = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
        TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR = 4'h6, TAP_EX2_DR = 4'h7,
        TAP_UP_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SH_IR = 4'hB,
        TAP_EX1_IR = 4'hC, TAP_PA_IR = 4'hD, TAP_EX2_IR = 4'hE, TAP_UP_IR = 4'hF
    } fpc_tap_t;

    // boot option bits, most significant first, bit 0 last
    typedef struct packed {
        logic [11:0] wdog_val;
        logic wdog_en;
        logic jtag_protect;
        logic encrypted_only;
        logic verify_protect;
        logic isp_data_secondary;
        logic primary_only;
        logic weak_pullup;
    } fpc_opt_t;

    typedef struct packed {
        fpc_tap_t tap;
        logic tck_q;
        logic tdo;
        logic [`FPC_IR_W-1:0] ir_sh;
        logic [`FPC_IR_W-1:0] cur_ir;
        logic [`FPC_DR_W-1:0] dr;
        logic in_system_programming;
        logic clamp;
        logic bgp;
        logic exit_pend;
        logic [`FPC_CNT_W-1:0] exit_cnt;
        logic [`FPC_ADDR_W-1:0] addr;
        logic flash_rd;
        logic burst;
        fpc_opt_t opt;
        logic [31:0] prdata;
        logic status_q;
        logic done_q;
        logic image;
        logic fell_back;
        logic cfg_err;
        logic reload;
    } fpc_st_t;
endpackage : fpc_pkg

/* File: rtl/fpc_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module fpc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } fpc_sync_st_t;

    fpc_sync_st_t st;
    fpc_sync_st_t next_st;

    always_comb
    begin
        next_st.s1 = d_in;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            st <= '0;
        else
            st <= next_st;
    end

    assign q_out = st.s2;
endmodule : fpc_sync
`default_nettype wire

/* File: rtl/fpc_cfg_timer.sv */
// load time meter from status release to load complete
`timescale 1ns/100ps
`default_nettype none
`include "fpc_defines.svh"
module fpc_cfg_timer #(
    parameter int MAX_CYC = 17450000
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // events
    input wire logic start_in,
    input wire logic stop_in,
    // result
    output logic [`FPC_CNT_W-1:0] count_out,
    output logic overrun_out
);
    localparam logic [`FPC_CNT_W-1:0] LIMIT = `FPC_CNT_W'(MAX_CYC);

    typedef struct packed {
        logic busy;
        logic ovr;
        logic [`FPC_CNT_W-1:0] cnt;
    } fpc_tmr_st_t;

    fpc_tmr_st_t st;
    fpc_tmr_st_t next_st;

    always_comb
    begin
        next_st = st;
        if (start_in)
        begin
            next_st.busy = 1'b1;
            next_st.ovr = 1'b0;
            next_st.cnt = '0;
        end
        else if (st.busy)
        begin
            if (stop_in)
                next_st.busy = 1'b0;
            else if (st.cnt == LIMIT)
                next_st.ovr = 1'b1;
            else
                next_st.cnt = st.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            st <= '0;
        else
            st <= next_st;
    end

    assign count_out = st.cnt;
    assign overrun_out = st.ovr;

    limit_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        st.busy && !start_in && !stop_in && st.cnt == LIMIT |=> overrun_out)
        else $error("load time overrun not flagged");
endmodule : fpc_cfg_timer
`default_nettype wire

/* File: rtl/fpc_top.sv */
// flash program command decoder and boot option controller
// Function
// - verify read command enables flash readback for checking
// - verify read takes explicit address or auto-increments in burst mode
// - background entry command enters background mode, flash sector open
// - background exit command leaves background mode
// - outside a mode only entry and exit commands act
// - weak pull-up option pulls pins up in configuration, else tri-state
// - primary-only option forces image 0, ignores pin, no fallback
// - without primary-only a failed load falls back to other image
// - option picks which image supplies the programming pin state
// - encrypted-only option flags error on unencrypted image
// - verify and jtag protect option bits, both off by default
// - watchdog enable option bit, on by default
// - twelve-bit watchdog value option, default all ones
// - load time from status rise to complete rise, limit 139.6 ms
// - tri-state entry command enters programming mode, pins tri-stated
// - held-pins entry drives pins from boundary scan, freezes core
// - exit completes after 200 us in run-test/idle
`timescale 1ns/100ps
`default_nettype none
`include "fpc_defines.svh"
module fpc_top #(
    parameter int EXIT_WAIT_CYC = int'($ceil(`FPC_EXIT_WAIT_US * `FPC_CLK_MHZ)),
    parameter int CFG_MAX_CYC = int'($floor(`FPC_CFG_MAX_MS * 1000.0 * `FPC_CLK_MHZ + 1.0e-6))
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // jtag pins
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    // configuration pins
    input wire logic config_state_low_pin_in,
    input wire logic load_complete_pin_in,
    input wire logic image_choice_pin_in,
    // image loader
    input wire logic load_fail_in,
    input wire logic image_present_in,
    input wire logic image_encrypted_in,
    input wire logic [1:0] isp_clamp_img_in,
    output logic image_select_out,
    output logic reload_out,
    output logic cfg_error_out,
    output logic cfg_time_overrun_out,
    // pin and core control
    output logic io_weak_pullup_out,
    output logic io_tristate_out,
    output logic io_clamp_out,
    output logic core_freeze_out,
    output logic isp_pin_clamp_out,
    // flash access
    output logic flash_access_out,
    output logic flash_rd_out,
    output logic [`FPC_ADDR_W-1:0] flash_addr_out,
    input wire logic [`FPC_DR_W-1:0] flash_data_in,
    // boot options
    output logic verify_protect_out,
    output logic jtag_protect_out,
    output logic wdog_en_out,
    output logic [11:0] wdog_value_out
);
    localparam logic [`FPC_CNT_W-1:0] EXIT_LAST = `FPC_CNT_W'(EXIT_WAIT_CYC - 1);

    logic [1:0] rst_q;
    logic rst_n;
    logic [5:0] pins;
    logic s_tck, s_tms, s_tdi, s_status, s_done, s_choice;
    logic tck_rise, tck_fall, in_mode, rd_act, cfg_start, configuring;
    logic setup, wr, mapped;
    logic [31:0] rd_mux;
    logic [`FPC_CNT_W-1:0] ctime;
    fpc_pkg::fpc_tap_t tap_nx;
    fpc_pkg::fpc_st_t st;
    fpc_pkg::fpc_st_t next_st;

    function automatic fpc_pkg::fpc_tap_t tap_next(input fpc_pkg::fpc_tap_t s, input logic m);
        fpc_pkg::fpc_tap_t r;
        unique case (s)
            fpc_pkg::TAP_RESET: r = m ? fpc_pkg::TAP_RESET : fpc_pkg::TAP_RTI;
            fpc_pkg::TAP_RTI: r = m ? fpc_pkg::TAP_SEL_DR : fpc_pkg::TAP_RTI;
            fpc_pkg::TAP_SEL_DR: r = m ? fpc_pkg::TAP_SEL_IR : fpc_pkg::TAP_CAP_DR;
            fpc_pkg::TAP_CAP_DR: r = m ? fpc_pkg::TAP_EX1_DR : fpc_pkg::TAP_SH_DR;
            fpc_pkg::TAP_SH_DR: r = m ? fpc_pkg::TAP_EX1_DR : fpc_pkg::TAP_SH_DR;
            fpc_pkg::TAP_EX1_DR: r = m ? fpc_pkg::TAP_UP_DR : fpc_pkg::TAP_PA_DR;
            fpc_pkg::TAP_PA_DR: r = m ? fpc_pkg::TAP_EX2_DR : fpc_pkg::TAP_PA_DR;
            fpc_pkg::TAP_EX2_DR: r = m ? fpc_pkg::TAP_UP_DR : fpc_pkg::TAP_SH_DR;
            fpc_pkg::TAP_UP_DR: r = m ? fpc_pkg::TAP_SEL_DR : fpc_pkg::TAP_RTI;
            fpc_pkg::TAP_SEL_IR: r = m ? fpc_pkg::TAP_RESET : fpc_pkg::TAP_CAP_IR;
            fpc_pkg::TAP_CAP_IR: r = m ? fpc_pkg::TAP_EX1_IR : fpc_pkg::TAP_SH_IR;
            fpc_pkg::TAP_SH_IR: r = m ? fpc_pkg::TAP_EX1_IR : fpc_pkg::TAP_SH_IR;
            fpc_pkg::TAP_EX1_IR: r = m ? fpc_pkg::TAP_UP_IR : fpc_pkg::TAP_PA_IR;
            fpc_pkg::TAP_PA_IR: r = m ? fpc_pkg::TAP_EX2_IR : fpc_pkg::TAP_PA_IR;
            fpc_pkg::TAP_EX2_IR: r = m ? fpc_pkg::TAP_UP_IR : fpc_pkg::TAP_SH_IR;
            fpc_pkg::TAP_UP_IR: r = m ? fpc_pkg::TAP_SEL_DR : fpc_pkg::TAP_RTI;
        endcase
        return r;
    endfunction : tap_next

    // reset release through two flops
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rst_q <= 2'h0;
        else
            rst_q <= {rst_q[0], 1'b1};
    end
    assign rst_n = rst_q[1];

    fpc_sync #(.W(6)) u_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .d_in({tck_in, tms_in, tdi_in, config_state_low_pin_in, load_complete_pin_in,
            image_choice_pin_in}),
        .q_out(pins)
    );
    assign {s_tck, s_tms, s_tdi, s_status, s_done, s_choice} = pins;

    fpc_cfg_timer #(.MAX_CYC(CFG_MAX_CYC)) u_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .start_in(cfg_start),
        .stop_in(s_done & ~st.done_q),
        .count_out(ctime),
        .overrun_out(cfg_time_overrun_out)
    );

    assign tck_rise = s_tck & ~st.tck_q;
    assign tck_fall = ~s_tck & st.tck_q;
    assign tap_nx = tap_next(st.tap, s_tms);
    assign in_mode = st.in_system_programming | st.bgp;
    // verify read acts only inside a mode
    assign rd_act = in_mode && (st.cur_ir == `FPC_CMD_VERIFY_READ);
    assign cfg_start = s_status & ~st.status_q;
    assign configuring = s_status & ~s_done;
    assign setup = psel_in & ~penable_in;
    assign wr = psel_in & penable_in & pwrite_in;
    assign mapped = paddr_in inside {`FPC_REG_CTRL, `FPC_REG_OPT, `FPC_REG_STAT,
        `FPC_REG_CTIME, `FPC_REG_FADDR};

    always_comb
    begin
        unique case (paddr_in)
            `FPC_REG_CTRL: rd_mux = {31'h0, st.burst};
            `FPC_REG_OPT: rd_mux = {13'h0, st.opt};
            `FPC_REG_STAT: rd_mux = {6'h0, st.cur_ir, 8'h0, cfg_time_overrun_out, configuring,
                st.cfg_err, st.image, st.exit_pend, st.clamp, st.bgp, st.in_system_programming};
            `FPC_REG_CTIME: rd_mux = {7'h0, ctime};
            `FPC_REG_FADDR: rd_mux = {9'h0, st.addr};
            default: rd_mux = 32'h0;
        endcase
    end

    always_comb
    begin
        next_st = st;
        next_st.flash_rd = 1'b0;
        next_st.reload = 1'b0;
        next_st.tck_q = s_tck;
        next_st.status_q = s_status;
        next_st.done_q = s_done;
        if (tck_rise)
        begin
            next_st.tap = tap_nx;
            if (st.tap == fpc_pkg::TAP_CAP_IR)
                next_st.ir_sh = `FPC_IR_CAPTURE;
            if (st.tap == fpc_pkg::TAP_SH_IR)
                next_st.ir_sh = {s_tdi, st.ir_sh[`FPC_IR_W-1:1]};
            if (st.tap == fpc_pkg::TAP_CAP_DR)
            begin
                next_st.dr = (rd_act && !st.opt.verify_protect) ? flash_data_in : '0;
                if (rd_act && st.burst)
                    next_st.addr = st.addr + 1'b1;
            end
            if (st.tap == fpc_pkg::TAP_SH_DR)
                next_st.dr = {s_tdi, st.dr[`FPC_DR_W-1:1]};
            if (tap_nx == fpc_pkg::TAP_CAP_DR && rd_act)
                next_st.flash_rd = 1'b1;
            if (tap_nx == fpc_pkg::TAP_UP_DR && rd_act && st.dr[`FPC_DR_EXPLICIT_BIT])
                next_st.addr = st.dr[`FPC_ADDR_W-1:0];
            if (tap_nx == fpc_pkg::TAP_RESET)
                next_st.cur_ir = `FPC_CMD_BYPASS;
        end
        if (tck_fall)
            next_st.tdo = (st.tap == fpc_pkg::TAP_SH_IR) ? st.ir_sh[0] : st.dr[0];
        if (st.exit_pend && st.tap == fpc_pkg::TAP_RTI)
        begin
            if (st.exit_cnt == EXIT_LAST)
            begin
                next_st.in_system_programming = 1'b0;
                next_st.clamp = 1'b0;
                next_st.exit_pend = 1'b0;
                next_st.exit_cnt = '0;
                if (!st.bgp)
                    next_st.cur_ir = `FPC_CMD_BYPASS;
            end
            else
                next_st.exit_cnt = st.exit_cnt + 1'b1;
        end
        else
            next_st.exit_cnt = '0;
        if (tck_rise && tap_nx == fpc_pkg::TAP_UP_IR)
        begin
            next_st.cur_ir = st.ir_sh;
            case (st.ir_sh)
                `FPC_CMD_ENTRY_TRISTATE:
                begin
                    next_st.in_system_programming = 1'b1;
                    next_st.clamp = 1'b0;
                    next_st.exit_pend = 1'b0;
                end
                `FPC_CMD_ENTRY_HELD:
                begin
                    next_st.in_system_programming = 1'b1;
                    next_st.clamp = 1'b1;
                    next_st.exit_pend = 1'b0;
                end
                `FPC_CMD_EXIT: next_st.exit_pend = st.in_system_programming;
                `FPC_CMD_BGP_ENTRY: next_st.bgp = 1'b1;
                `FPC_CMD_BGP_EXIT: next_st.bgp = 1'b0;
                // other codes dropped outside a mode
                default: next_st.cur_ir = in_mode ? st.ir_sh : `FPC_CMD_BYPASS;
            endcase
        end
        // background mode survives reconfiguration until host exit
        if (cfg_start)
        begin
            next_st.image = st.opt.primary_only ? 1'b0 : s_choice;
            next_st.fell_back = 1'b0;
            next_st.cfg_err = 1'b0;
        end
        if (configuring && load_fail_in && !cfg_start)
        begin
            // fall back to other image once
            if (!st.opt.primary_only && !st.fell_back)
            begin
                next_st.image = ~st.image;
                next_st.fell_back = 1'b1;
                next_st.reload = 1'b1;
            end
            else
                next_st.cfg_err = 1'b1;
        end
        if (configuring && st.opt.encrypted_only && image_present_in && !image_encrypted_in)
            next_st.cfg_err = 1'b1;
        if (wr && paddr_in == `FPC_REG_CTRL)
            next_st.burst = pwdata_in[`FPC_CTRL_BURST_BIT];
        if (wr && paddr_in == `FPC_REG_OPT)
            next_st.opt = pwdata_in[`FPC_OPT_W-1:0];
        if (setup && !pwrite_in)
            next_st.prdata = rd_mux;
    end

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.cur_ir <= `FPC_CMD_BYPASS;
            st.opt <= `FPC_OPT_RST;
        end
        else
            st <= next_st;
    end

    assign prdata_out = st.prdata;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~mapped;
    assign tdo_out = st.tdo;
    assign tdo_oe_out = (st.tap == fpc_pkg::TAP_SH_IR) || (st.tap == fpc_pkg::TAP_SH_DR);
    assign image_select_out = st.image;
    assign reload_out = st.reload;
    assign cfg_error_out = st.cfg_err;
    assign io_weak_pullup_out = configuring & st.opt.weak_pullup;
    assign io_tristate_out = (configuring & ~st.opt.weak_pullup) | (st.in_system_programming & ~st.clamp);
    assign io_clamp_out = st.in_system_programming & st.clamp;
    assign core_freeze_out = st.in_system_programming & st.clamp;
    assign isp_pin_clamp_out = isp_clamp_img_in[st.opt.isp_data_secondary];
    assign flash_access_out = in_mode;
    assign flash_rd_out = st.flash_rd;
    assign flash_addr_out = st.addr;
    assign verify_protect_out = st.opt.verify_protect;
    assign jtag_protect_out = st.opt.jtag_protect;
    assign wdog_en_out = st.opt.wdog_en;
    assign wdog_value_out = st.opt.wdog_val;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    sequence s_dec(logic [`FPC_IR_W-1:0] code);
        tck_rise && tap_nx == fpc_pkg::TAP_UP_IR && st.ir_sh == code;
    endsequence

    bgp_entry_a: assert property (s_dec(`FPC_CMD_BGP_ENTRY) |=> st.bgp && flash_access_out)
        else $error("background entry not taken");
    bgp_exit_a: assert property (s_dec(`FPC_CMD_BGP_EXIT) |=> !st.bgp)
        else $error("background exit not taken");
    hiz_entry_a: assert property (s_dec(`FPC_CMD_ENTRY_TRISTATE) |=> io_tristate_out && !io_clamp_out)
        else $error("tri-state entry wrong");
    held_entry_a: assert property (s_dec(`FPC_CMD_ENTRY_HELD) |=> core_freeze_out && io_clamp_out)
        else $error("held-pin entry wrong");
    exit_wait_a: assert property ($fell(st.in_system_programming) |-> $past(st.exit_cnt) == EXIT_LAST)
        else $error("mode left before wait");
    read_gate_a: assert property (flash_rd_out |-> in_mode)
        else $error("flash read outside mode");
    primary_only_a: assert property (cfg_start && st.opt.primary_only |=> !image_select_out)
        else $error("primary-only did not force image 0");
    fallback_a: assert property (configuring && load_fail_in && !cfg_start && !st.opt.primary_only
        && !st.fell_back |=> reload_out && image_select_out != $past(st.image))
        else $error("no fallback on failed load");
    enc_err_a: assert property (configuring && st.opt.encrypted_only && image_present_in
        && !image_encrypted_in |=> cfg_error_out)
        else $error("unencrypted image not flagged");
    burst_inc_a: assert property (tck_rise && st.tap == fpc_pkg::TAP_CAP_DR && rd_act && st.burst
        |=> flash_addr_out == $past(st.addr) + 1'b1)
        else $error("burst address did not advance");
endmodule : fpc_top
`default_nettype wire

/* File: test/fpc_jtag_host.sv */
// jtag programming host model driving the tap pins
`timescale 1ns/100ps
`default_nettype none
module fpc_jtag_host (
    // clock
    input wire logic clk_in,
    // tap pins
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    input wire logic tdo_in
);
    initial
    begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // one tck period: low 5 clk, high 3 clk, tdo taken before the rise
    task tick(input logic m, input logic d, output logic o);
        tms_out <= m;
        tdi_out <= d;
        repeat (5) @(posedge clk_in);
        o = tdo_in;
        tck_out <= 1'b1;
        repeat (3) @(posedge clk_in);
        tck_out <= 1'b0;
    endtask : tick
    task idle(input int n);
        logic o;
        repeat (n) tick(1'b0, ~tdi_out, o);
    endtask : idle
    task reset_tap();
        logic o;
        repeat (5) tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b1, o);
    endtask : reset_tap
    // idle to idle scan, ir picks the instruction path
    task scan(input logic ir, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        int n;
        n = ir ? 10 : 32;
        dout = '0;
        tick(1'b1, 1'b0, o);
        if (ir)
            tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
        tick(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
    endtask : scan
    // only the host sends codes, only supported ones
    task ir_scan(input logic [9:0] code);
        logic [31:0] o;
        scan(1'b1, {22'h0, code}, o);
    endtask : ir_scan
endmodule : fpc_jtag_host
`default_nettype wire

/* File: test/tb_flash_program_command_and_boot_options.sv */
// testbench for the flash program command and boot option block
`timescale 1ns/100ps
`default_nettype none
module tb_flash_program_command_and_boot_options;
    logic clk_in, arst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, flash_data_in, rv;
    logic tck_in, tms_in, tdi_in, tdo_out, tdo_oe_out, ev;
    logic config_state_low_pin_in, load_complete_pin_in, image_choice_pin_in;
    logic load_fail_in, image_present_in, image_encrypted_in, image_select_out;
    logic [1:0] isp_clamp_img_in;
    logic reload_out, cfg_error_out, cfg_time_overrun_out, io_weak_pullup_out;
    logic io_tristate_out, io_clamp_out, core_freeze_out, isp_pin_clamp_out;
    logic flash_access_out, flash_rd_out, verify_protect_out, jtag_protect_out;
    logic wdog_en_out;
    logic [11:0] wdog_value_out;
    logic [22:0] flash_addr_out;
    int fails = 0, checks = 0, rd_cnt = 0, n;
    fpc_top #(.EXIT_WAIT_CYC(20), .CFG_MAX_CYC(200)) i_fpc_top (.clk_in, .arst_n_in,
        .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
        .pslverr_out, .tck_in, .tms_in, .tdi_in, .tdo_out, .tdo_oe_out,
        .config_state_low_pin_in, .load_complete_pin_in, .image_choice_pin_in, .load_fail_in,
        .image_present_in, .image_encrypted_in, .isp_clamp_img_in, .image_select_out,
        .reload_out, .cfg_error_out, .cfg_time_overrun_out, .io_weak_pullup_out,
        .io_tristate_out, .io_clamp_out, .core_freeze_out, .isp_pin_clamp_out,
        .flash_access_out, .flash_rd_out, .flash_addr_out, .flash_data_in,
        .verify_protect_out, .jtag_protect_out, .wdog_en_out, .wdog_value_out);
    fpc_jtag_host i_fpc_jtag_host (.clk_in, .tck_out(tck_in), .tms_out(tms_in),
        .tdi_out(tdi_in), .tdo_in(tdo_out));
    always #4 clk_in = ~clk_in;
    always @(posedge clk_in)
        if (flash_rd_out === 1'b1)
            rd_cnt++;
    task close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    task chk(input string s, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x)
        begin
            fails++;
            $display("Error %s expected %h seen %h", s, x, g);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do
            @(posedge clk_in);
        while (pready_out !== 1'b1);
        r = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask : apb
    task cfg_start();
        config_state_low_pin_in <= 1'b0;
        load_complete_pin_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        config_state_low_pin_in <= 1'b1;
        repeat (6) @(posedge clk_in);
    endtask : cfg_start
    task fail_pulse(output int r);
        r = 0;
        load_fail_in <= 1'b1;
        @(posedge clk_in);
        load_fail_in <= 1'b0;
        repeat (4)
        begin
            @(posedge clk_in);
            r += (reload_out === 1'b1);
        end
    endtask : fail_pulse
    task t_reset();
        apb(1'b0, 8'h04, 32'h0, rv, ev);
        chk("opt", 32'h7FFC1, rv);
        chk("wdog", 12'hFFF, wdog_value_out);
        chk("prot", 3'b001, {verify_protect_out, jtag_protect_out, wdog_en_out});
        apb(1'b0, 8'h40, 32'h0, rv, ev);
        chk("slverr", 1'b1, ev);
        apb(1'b1, 8'h04, 32'h2D1A9, rv, ev);
        chk("wdog_w", 12'h5A3, wdog_value_out);
        chk("prot_w", 3'b110, {verify_protect_out, jtag_protect_out, wdog_en_out});
        apb(1'b1, 8'h04, 32'h7FFC1, rv, ev);
    endtask : t_reset
    task t_gate();
        i_fpc_jtag_host.reset_tap();
        n = rd_cnt;
        i_fpc_jtag_host.ir_scan(10'h205);
        i_fpc_jtag_host.scan(1'b0, 32'h80000123, rv);
        chk("gate_rd", n, rd_cnt);
        chk("gate_acc", 24'h0, {flash_access_out, flash_addr_out});
        apb(1'b0, 8'h08, 32'h0, rv, ev);
        chk("gate_ir", 10'h3FF, rv[25:16]);
    endtask : t_gate
    task t_verify();
        apb(1'b1, 8'h00, 32'h1, rv, ev);
        i_fpc_jtag_host.ir_scan(10'h2CC);
        chk("tri", 2'b11, {io_tristate_out, flash_access_out});
        i_fpc_jtag_host.ir_scan(10'h205);
        apb(1'b0, 8'h08, 32'h0, rv, ev);
        chk("ir", 10'h205, rv[25:16]);
        n = rd_cnt;
        i_fpc_jtag_host.scan(1'b0, 32'h80012345, rv);
        flash_data_in <= 32'h3C5A9617;
        i_fpc_jtag_host.scan(1'b0, 32'h0, rv);
        chk("rd_cnt", n + 2, rd_cnt);
        chk("rd_data", flash_data_in, rv);
        chk("burst", 23'h012346, flash_addr_out);
        apb(1'b1, 8'h00, 32'h0, rv, ev);
        i_fpc_jtag_host.scan(1'b0, 32'h80000100, rv);
        i_fpc_jtag_host.scan(1'b0, 32'h0, rv);
        chk("explicit", 23'h000100, flash_addr_out);
        i_fpc_jtag_host.ir_scan(10'h201);
        chk("exit_wait", 1'b1, io_tristate_out);
        i_fpc_jtag_host.idle(4);
        chk("exit", 2'b00, {io_tristate_out, flash_access_out});
    endtask : t_verify
    task t_held();
        i_fpc_jtag_host.ir_scan(10'h233);
        chk("held", 3'b110, {io_clamp_out, core_freeze_out, io_tristate_out});
        i_fpc_jtag_host.ir_scan(10'h201);
        i_fpc_jtag_host.idle(4);
        chk("held_exit", 2'b00, {io_clamp_out, core_freeze_out});
    endtask : t_held
    task t_bgp();
        i_fpc_jtag_host.ir_scan(10'h199);
        chk("bgp", 3'b100, {flash_access_out, core_freeze_out, io_tristate_out});
        cfg_start();
        chk("bgp_kept", 1'b1, flash_access_out);
        i_fpc_jtag_host.ir_scan(10'h166);
        chk("bgp_off", 1'b0, flash_access_out);
    endtask : t_bgp
    task t_boot();
        image_choice_pin_in <= 1'b1;
        cfg_start();
        chk("img_pin", 2'b11, {image_select_out, io_weak_pullup_out});
        fail_pulse(n);
        chk("fallback", 3'b100, {n == 1, image_select_out, cfg_error_out});
        fail_pulse(n);
        chk("fail2", 2'b01, {n != 0, cfg_error_out});
        apb(1'b1, 8'h04, 32'h7FFC2, rv, ev);
        cfg_start();
        chk("prim", 2'b00, {image_select_out, io_weak_pullup_out});
        fail_pulse(n);
        chk("prim_fail", 3'b001, {n != 0, image_select_out, cfg_error_out});
        apb(1'b1, 8'h04, 32'h7FFD5, rv, ev);
        chk("isp_img1", 1'b1, isp_pin_clamp_out);
        image_present_in <= 1'b1;
        cfg_start();
        chk("enc_err", 1'b1, cfg_error_out);
        image_encrypted_in <= 1'b1;
        image_choice_pin_in <= 1'b0;
        cfg_start();
        chk("enc_ok", 2'b00, {image_select_out, cfg_error_out});
        isp_clamp_img_in <= 2'b01;
        apb(1'b1, 8'h04, 32'h7FFC1, rv, ev);
        chk("isp_img0", 1'b1, isp_pin_clamp_out);
    endtask : t_boot
    task t_time(input int c, input logic ovr);
        cfg_start();
        repeat (c - 6) @(posedge clk_in);
        load_complete_pin_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        apb(1'b0, 8'h0C, 32'h0, rv, ev);
        n = (c < 200) ? c : 200;
        chk("ctime", 1'b1, rv >= n - 1 && rv <= n + 1);
        chk("overrun", ovr, cfg_time_overrun_out);
    endtask : t_time
    initial
    begin
        {clk_in, arst_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        {config_state_low_pin_in, load_complete_pin_in, image_choice_pin_in} = '0;
        {load_fail_in, image_present_in, image_encrypted_in} = '0;
        isp_clamp_img_in = 2'b10;
        flash_data_in = 32'hA5C30F96;
        repeat (16) @(posedge clk_in);
        arst_n_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        t_reset();
        t_gate();
        t_verify();
        t_held();
        t_bgp();
        t_boot();
        t_time(150, 1'b0);
        t_time(250, 1'b1);
        close_out();
    end
    initial
    begin
        #500000;
        fails++;
        close_out();
    end
endmodule : tb_flash_program_command_and_boot_options
`default_nettype wire
